// ---- design/clock_switch_pkg.sv ----
// Purpose: constants for the clock switch and system prescaler
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   register fields sit in byte lane 0
package clock_switch_pkg;
   // register byte addresses
   localparam logic [3:0] ADDR_SELECT_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_SOURCE_CONFIG  = 4'h4;
   localparam logic [3:0] ADDR_SOURCE_STATUS  = 4'h8;
   localparam logic [3:0] ADDR_PRESCALER      = 4'hc;
   // select control fields
   localparam int SEL_RC_SUT_LSB  = 6;
   localparam int SEL_EXT_SUT_LSB = 4;
   localparam int SEL_RC_EN_BIT   = 3;
   localparam int SEL_EXT_EN_BIT  = 2;
   localparam int SEL_SOURCE_BIT  = 0;
   // source config fields
   localparam int CFG_RC_LSB  = 4;
   localparam int CFG_EXT_LSB = 0;
   // status fields
   localparam int STA_RC_RUN_BIT  = 1;
   localparam int STA_EXT_RUN_BIT = 0;
   // prescaler fields
   localparam int PRE_CE_BIT = 7;
   // reset and fuse values, division limit, unlock code
   localparam logic [3:0] RC_CFG_RESET    = 4'h2;
   localparam logic [3:0] RC_FUSE_CODE    = 4'h2;
   localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
   localparam logic [3:0] DIV_RESET_DIV8  = 4'h3;
   localparam logic [3:0] DIV_MAX         = 4'h8;
   localparam logic [7:0] PRE_UNLOCK      = 8'h80;
   // change-enable window, in bus clock cycles
   localparam int         CE_WINDOW_CYCLES = 4;
   localparam logic [1:0] CE_TMR_START     = 2'(CE_WINDOW_CYCLES - 1);
   // cycles after reset release before fuses are captured
   localparam logic [1:0] FUSE_LOAD_AT     = 2'h2;

   typedef enum logic [1:0] {
      MUX_ON,
      MUX_DROP,
      MUX_TAKE
   } mux_state_t;
endpackage : clock_switch_pkg

// ---- design/clock_switch_and_prescaler.sv ----
// Purpose: clock source switch, glitch-free prescaler, clock output pin
// Assumes: source clocks are oversampled by i_clk; fuses are static pins
// Notes:   clock sampling path is not reset so the pin runs during reset
// Contract
// - RC start-up field loaded from fuses when RC chosen; writes ignored.
// - external start-up field loaded from fuses when external chosen, 00 when RC chosen; writable; used at next start;
//   a start takes the value held before the enable edge (00 at fuse load).
// - RC enable bit starts and stops the RC oscillator.
// - external enable bit starts and stops the external oscillator.
// - selector one picks external source, zero picks RC.
// - after reset selector is one when fuses choose external source.
// - RC config field resets to 0010; firmware must leave it alone.
// - external config field loaded from fuses when external chosen, 0000 when RC chosen; firmware may rewrite it.
// - RC running flag mirrors the RC oscillator state.
// - external running flag mirrors the external oscillator state.
// - upper six status bits read zero.
// - clock output fuse enables the pin, even in reset; in reset the pin shows the raw rc clock.
// - pin carries the clock after the prescaler.
// - division applies to cpu, io, adc and flash clocks.
// - prescaler changes produce no glitch or short period.
// - prescaler is a counter on the undivided clock, not readable.
// - new division takes effect after the old period ends.
// - prescaler change needs unlock write then value write within four cycles.
// - change enable clears after four cycles or on value write.
// - division codes 0 to 8 mean divide by two to the code.
// - division resets to 0011 with divide-by-eight fuse, else 0000.
`timescale 1ns/1ps
`default_nettype none
module clock_switch_and_prescaler
   import clock_switch_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // avalon-mm slave
   input  wire logic [3:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic      [31:0] o_readdata,
   output logic             o_waitrequest,
   // fuses
   input  wire logic [3:0]  i_source_config_fuses,
   input  wire logic [1:0]  i_startup_time_fuses,
   input  wire logic        i_clock_output_fuse,
   input  wire logic        i_divide_by_eight_fuse,
   // oscillators
   input  wire logic        i_rc_clk,
   input  wire logic        i_ext_clk,
   input  wire logic        i_rc_running,
   input  wire logic        i_ext_running,
   output logic             o_rc_osc_enable,
   output logic             o_ext_osc_enable,
   output logic      [3:0]  o_rc_source_config,
   output logic      [3:0]  o_ext_source_config,
   output logic      [1:0]  o_rc_startup_time,
   output logic      [1:0]  o_ext_startup_time,
   // divided clock for cpu, io, adc and flash
   output logic             o_sys_clk,
   // clock output pin
   output logic             o_clock_output_pin,
   output logic             o_clock_output_oe
);
   import clock_switch_pkg::*;

   typedef struct packed {
      logic       loaded;
      logic [1:0] init;
      logic [3:0] fcfg_s1;
      logic [3:0] fcfg_s2;
      logic [1:0] fsut_s1;
      logic [1:0] fsut_s2;
      logic       fd8_s1;
      logic       fd8_s2;
      logic       rcr_s1;
      logic       rcr_s2;
      logic       exr_s1;
      logic       exr_s2;
      logic [1:0] rc_sut;
      logic [1:0] ext_sut;
      logic [1:0] ext_sut_app;
      logic       rc_en;
      logic       ext_en;
      logic       sel;
      logic [3:0] rc_cfg;
      logic [3:0] ext_cfg;
      logic       ce;
      logic [1:0] ce_tmr;
      logic [3:0] div_reg;
      logic [3:0] div_act;
      logic       pend;
      logic [7:0] cnt;
      logic       mux_src;
      mux_state_t mstate;
      logic       mux_prev;
      logic       sys_clk;
      logic       waitreq;
      logic [7:0] rdata;
   } state_t;

   typedef struct packed {
      logic rc_s1;
      logic rc_s2;
      logic ext_s1;
      logic ext_s2;
      logic fco_s1;
      logic fco_s2;
      logic pin;
      logic oe;
   } clk_path_t;

   localparam state_t ST_RESET = '{
      rc_en:   1'b1,
      rc_cfg:  RC_CFG_RESET,
      div_reg: DIV_RESET_PLAIN,
      div_act: DIV_RESET_PLAIN,
      mstate:  MUX_ON,
      waitreq: 1'b1,
      default: '0
   };

   state_t    st;
   state_t    next_st;
   clk_path_t ck;
   clk_path_t next_ck;
   logic       take;
   logic       wr_take;
   logic       is_rc;
   logic       mux_lvl;
   logic       tick;
   logic [7:0] wd;

   function automatic logic [7:0] period_mask(input logic [3:0] d);
      period_mask = 8'((9'h1 << d) - 9'h1);
   endfunction : period_mask

   function automatic logic divided_level(input logic [7:0] c, input logic [3:0] d,
                                          input logic raw);
      divided_level = (d == 4'h0) ? raw : c[3'(d - 4'h1)];
   endfunction : divided_level

   always_comb begin
      next_st = st;
      next_ck = ck;
      wd      = i_writedata[7:0];
      take    = (i_read | i_write) & ~st.waitreq;
      wr_take = take & i_write & i_byteenable[0];
      is_rc   = (st.fcfg_s2 == RC_FUSE_CODE);
      // synchronisers
      next_st.fcfg_s1 = i_source_config_fuses;
      next_st.fcfg_s2 = st.fcfg_s1;
      next_st.fsut_s1 = i_startup_time_fuses;
      next_st.fsut_s2 = st.fsut_s1;
      next_st.fd8_s1  = i_divide_by_eight_fuse;
      next_st.fd8_s2  = st.fd8_s1;
      next_st.rcr_s1  = i_rc_running;
      next_st.rcr_s2  = st.rcr_s1;
      next_st.exr_s1  = i_ext_running;
      next_st.exr_s2  = st.exr_s1;
      next_ck.rc_s1   = i_rc_clk;
      next_ck.rc_s2   = ck.rc_s1;
      next_ck.ext_s1  = i_ext_clk;
      next_ck.ext_s2  = ck.ext_s1;
      next_ck.fco_s1  = i_clock_output_fuse;
      next_ck.fco_s2  = ck.fco_s1;
      // fuse capture once the synchronisers have filled
      if (!st.loaded) begin
         next_st.init = st.init + 2'h1;
         if (st.init == FUSE_LOAD_AT) begin
            next_st.loaded  = 1'b1;
            next_st.rc_sut  = is_rc ? st.fsut_s2 : 2'h0;
            next_st.ext_sut = is_rc ? 2'h0 : st.fsut_s2;
            next_st.ext_sut_app = next_st.ext_sut;
            next_st.ext_cfg = is_rc ? 4'h0 : st.fcfg_s2;
            next_st.sel     = ~is_rc;
            next_st.ext_en  = ~is_rc;
            next_st.rc_en   = is_rc;
            next_st.div_reg = st.fd8_s2 ? DIV_RESET_DIV8 : DIV_RESET_PLAIN;
            next_st.div_act = next_st.div_reg;
            next_st.cnt     = 8'h00;
         end
      end
      // bus: one wait cycle, then answer
      next_st.waitreq = ~((i_read | i_write) & st.waitreq & st.loaded);
      if ((i_read | i_write) & st.waitreq) begin
         if (i_address == ADDR_SELECT_CONTROL) begin
            next_st.rdata = {st.rc_sut, st.ext_sut, st.rc_en, st.ext_en, 1'b0, st.sel};
         end else if (i_address == ADDR_SOURCE_CONFIG) begin
            next_st.rdata = {st.rc_cfg, st.ext_cfg};
         end else if (i_address == ADDR_SOURCE_STATUS) begin
            next_st.rdata = {6'h00, st.rcr_s2, st.exr_s2};
         end else if (i_address == ADDR_PRESCALER) begin
            next_st.rdata = {st.ce, 3'h0, st.div_reg};
         end else begin
            next_st.rdata = 8'h00;
         end
      end
      // change-enable timeout, never extended
      if (st.ce) begin
         if (st.ce_tmr == 2'h0) begin
            next_st.ce = 1'b0;
         end else begin
            next_st.ce_tmr = st.ce_tmr - 2'h1;
         end
      end
      if (wr_take) begin
         if (i_address == ADDR_SELECT_CONTROL) begin
            next_st.ext_sut = wd[SEL_EXT_SUT_LSB +: 2];
            next_st.rc_en   = wd[SEL_RC_EN_BIT];
            next_st.ext_en  = wd[SEL_EXT_EN_BIT];
            next_st.sel     = wd[SEL_SOURCE_BIT];
         end else if (i_address == ADDR_SOURCE_CONFIG) begin
            next_st.rc_cfg  = wd[CFG_RC_LSB +: 4];
            next_st.ext_cfg = wd[CFG_EXT_LSB +: 4];
         end else if (i_address == ADDR_PRESCALER) begin
            if (wd == PRE_UNLOCK) begin
               if (!st.ce) begin
                  next_st.ce     = 1'b1;
                  next_st.ce_tmr = CE_TMR_START;
               end
            end else if (!wd[PRE_CE_BIT] && st.ce) begin
               next_st.ce = 1'b0;
               if (wd[3:0] <= DIV_MAX) begin
                  next_st.div_reg = wd[3:0];
                  next_st.pend    = 1'b1;
               end
            end
         end
      end
      // start-up time takes effect on the enable edge
      if (next_st.ext_en && !st.ext_en) begin
         next_st.ext_sut_app = st.ext_sut;
      end
      // glitch-free source mux
      case (st.mstate)
         MUX_ON: begin
            if (st.sel != st.mux_src) begin
               next_st.mstate = MUX_DROP;
            end
         end
         MUX_DROP: begin
            if (!(st.mux_src ? ck.ext_s2 : ck.rc_s2)) begin
               next_st.mux_src = st.sel;
               next_st.mstate  = MUX_TAKE;
            end
         end
         MUX_TAKE: begin
            if (!(st.mux_src ? ck.ext_s2 : ck.rc_s2)) begin
               next_st.mstate = MUX_ON;
            end
         end
         default: begin
            next_st.mstate = MUX_ON;
         end
      endcase
      mux_lvl = (st.mstate != MUX_TAKE) & (st.mux_src ? ck.ext_s2 : ck.rc_s2);
      next_st.mux_prev = mux_lvl;
      tick = mux_lvl & ~st.mux_prev;
      // prescaler counts undivided edges, switches only at a period end
      if (tick) begin
         if ((st.cnt & period_mask(st.div_act)) == period_mask(st.div_act)) begin
            next_st.cnt = 8'h00;
            if (next_st.pend) begin
               next_st.div_act = next_st.div_reg;
               next_st.pend    = 1'b0;
            end
         end else begin
            next_st.cnt = st.cnt + 8'h01;
         end
      end
      next_st.sys_clk = divided_level(next_st.cnt, next_st.div_act, mux_lvl);
      // pin shows raw rc clock while in reset
      next_ck.pin = st.loaded ? st.sys_clk : ck.rc_s2;
      next_ck.oe  = ck.fco_s2;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge i_clk) begin
      ck <= next_ck;
   end

   assign o_readdata          = {24'h00_0000, st.rdata};
   assign o_waitrequest       = st.waitreq;
   assign o_rc_osc_enable     = st.rc_en;
   assign o_ext_osc_enable    = st.ext_en;
   assign o_rc_source_config  = st.rc_cfg;
   assign o_ext_source_config = st.ext_cfg;
   assign o_rc_startup_time   = st.rc_sut;
   assign o_ext_startup_time  = st.ext_sut_app;
   assign o_sys_clk           = st.sys_clk;
   assign o_clock_output_pin  = ck.pin;
   assign o_clock_output_oe   = ck.oe;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_status_upper_zero: assert property (
      (take && i_read && i_address == ADDR_SOURCE_STATUS) |-> o_readdata[7:2] == 6'h00)
      else $error("status upper bits not zero");
   a_status_flags: assert property (
      (take && i_read && i_address == ADDR_SOURCE_STATUS)
      |-> o_readdata[1:0] == {$past(st.rcr_s2), $past(st.exr_s2)})
      else $error("running flags misreported");
   a_rc_sut_locked: assert property (
      (st.loaded && wr_take && i_address == ADDR_SELECT_CONTROL) |=> $stable(o_rc_startup_time))
      else $error("rc startup field changed by write");
   a_sel_after_load: assert property (
      $rose(st.loaded) |-> st.sel == (st.ext_cfg != 4'h0 || $past(st.fcfg_s2) != RC_FUSE_CODE))
      else $error("selector not set from fuses");
   a_div_reset_load: assert property (
      $rose(st.loaded) |-> st.div_act == ($past(st.fd8_s2) ? DIV_RESET_DIV8 : DIV_RESET_PLAIN))
      else $error("division not loaded from fuse");
   a_ce_timeout: assert property (
      $rose(st.ce) |-> ##[1:4] !st.ce)
      else $error("change enable outlived its window");
   a_div_accept: assert property (
      (wr_take && i_address == ADDR_PRESCALER && st.ce && !wd[PRE_CE_BIT] && wd[3:0] <= DIV_MAX)
      |=> st.div_reg == $past(wd[3:0]) && (st.pend || st.div_act == st.div_reg))
      else $error("division write not accepted");
   a_div_refused: assert property (
      (wr_take && i_address == ADDR_PRESCALER && !st.ce) |=> $stable(st.div_reg))
      else $error("division changed without unlock");
   a_mux_handover: assert property (
      (st.mstate == MUX_TAKE) |-> !st.mux_prev && !mux_lvl)
      else $error("mux passed clock while handing over");
   a_pin_enable: assert property (
      (ck.fco_s2 && st.loaded) |=> o_clock_output_oe)
      else $error("clock output not enabled by fuse");
   a_div1_follows: assert property (
      (next_st.div_act == 4'h0 && st.loaded) |=> o_sys_clk == $past(mux_lvl))
      else $error("undivided clock not passed");
   // register fields, fuse load, pin and prescaler
   a_rc_en_write: assert property (
      (wr_take && i_address == ADDR_SELECT_CONTROL) |=> o_rc_osc_enable == $past(wd[SEL_RC_EN_BIT]))
      else $error("rc enable not written");
   a_ext_en_write: assert property (
      (wr_take && i_address == ADDR_SELECT_CONTROL) |=> o_ext_osc_enable == $past(wd[SEL_EXT_EN_BIT]))
      else $error("ext enable not written");
   a_source_write: assert property (
      (wr_take && i_address == ADDR_SELECT_CONTROL) |=> st.sel == $past(wd[SEL_SOURCE_BIT]))
      else $error("source selector not written");
   a_ext_sut_start: assert property (
      ($past(st.loaded) && $rose(st.ext_en)) |-> o_ext_startup_time == $past(st.ext_sut))
      else $error("ext start-up not applied at start");
   a_rc_cfg_load: assert property (
      $rose(st.loaded) |-> o_rc_source_config == RC_CFG_RESET)
      else $error("rc config not at reset value");
   a_rc_sut_load: assert property (
      $rose(st.loaded) |-> o_rc_startup_time == (($past(st.fcfg_s2) == RC_FUSE_CODE) ? $past(st.fsut_s2) : 2'h0))
      else $error("rc start-up not loaded from fuses");
   a_pin_follows: assert property (
      st.loaded |=> o_clock_output_pin == $past(o_sys_clk))
      else $error("pin not showing divided clock");
   a_cnt_in_period: assert property (
      (st.cnt & ~period_mask(st.div_act)) == 8'h00)
      else $error("prescaler count beyond its period");
   a_ce_needs_unlock: assert property (
      (!st.ce && !(wr_take && i_address == ADDR_PRESCALER && wd == PRE_UNLOCK)) |=> !st.ce)
      else $error("change enable set without unlock");
endmodule : clock_switch_and_prescaler
`default_nettype wire

// ---- dv/osc_model.sv ----
// Purpose: behavioural oscillator feeding the clock switch
// Assumes: free-running phase, gated by the enable
// Notes:   clock rests low while stopped
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
   parameter real HALF_NS   = 62.5,
   parameter int  START_CYC = 4
) (
   input  wire logic i_enable,
   output logic      o_clk,
   output logic      o_running
);
   logic phase = 1'b0;
   initial begin
      #3;
      forever #(HALF_NS) phase = ~phase;
   end
   initial o_running = 1'b0;
   // flag rises only after start-up
   always @(i_enable) begin
      if (i_enable) begin
         repeat (START_CYC) @(posedge phase);
         o_running = i_enable;
      end else begin
         o_running = 1'b0;
      end
   end
   assign o_clk = phase & o_running;
endmodule : osc_model
`default_nettype wire

// ---- dv/clock_switch_and_prescaler_tb_top.sv ----
// Purpose: self-checking bench for the clock switch and prescaler
// Assumes: rc period 5 and ext period 8 bus cycles
// Notes:   fuses change only while in reset
`timescale 1ns/1ps
`default_nettype none
module clock_switch_and_prescaler_tb_top;
   import clock_switch_pkg::*;
   logic        i_clk = 1'b0, i_nrst = 1'b0, i_read = 1'b0, i_write = 1'b0;
   logic [3:0]  i_address = 4'h0, i_source_config_fuses = 4'h2;
   logic [31:0] i_writedata = 32'h0000_0000;
   logic [1:0]  i_startup_time_fuses = 2'h1;
   logic        i_clock_output_fuse = 1'b1, i_divide_by_eight_fuse = 1'b1;
   logic [31:0] o_readdata;
   logic        o_waitrequest, i_rc_clk, i_ext_clk, i_rc_running, i_ext_running, last_sys = 1'b0;
   logic        o_rc_osc_enable, o_ext_osc_enable, o_sys_clk, o_clock_output_pin, o_clock_output_oe;
   logic [3:0]  o_rc_source_config, o_ext_source_config;
   logic [1:0]  o_rc_startup_time, o_ext_startup_time;
   logic [7:0]  q;
   int          n_errors = 0, n_checks = 0, up = 0;

   always #12.5 i_clk = ~i_clk;

   clock_switch_and_prescaler uut (.i_clk, .i_nrst, .i_address, .i_read, .i_write, .i_writedata,
      .i_byteenable(4'h1), .o_readdata, .o_waitrequest, .i_source_config_fuses, .i_startup_time_fuses,
      .i_clock_output_fuse, .i_divide_by_eight_fuse, .i_rc_clk, .i_ext_clk, .i_rc_running,
      .i_ext_running, .o_rc_osc_enable, .o_ext_osc_enable, .o_rc_source_config, .o_ext_source_config,
      .o_rc_startup_time, .o_ext_startup_time, .o_sys_clk, .o_clock_output_pin, .o_clock_output_oe);
   osc_model #(.HALF_NS(62.5), .START_CYC(4)) rc_osc (.i_enable(o_rc_osc_enable), .o_clk(i_rc_clk),
      .o_running(i_rc_running));
   osc_model #(.HALF_NS(100.0), .START_CYC(3)) ext_osc (.i_enable(o_ext_osc_enable), .o_clk(i_ext_clk),
      .o_running(i_ext_running));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk8

   task automatic chk_int(input int got, input int exp, input string what);
      n_checks++;
      if (got != exp) begin
         n_errors++;
         $display("ERROR %0t %s: got %0d expected %0d", $time, what, got, exp);
      end
   endtask : chk_int

   // pin trails the divided clock by one cycle, driven throughout
   always @(negedge i_clk) begin
      up <= i_nrst ? up + 1 : 0;
      if ($time > 70) chk8(o_clock_output_oe, 8'h01, "pin enable");
      if (up > 4) chk8(o_clock_output_pin, last_sys, "pin clock");
      last_sys <= o_sys_clk;
   end

   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      logic wt;
      int   n;
      wt = 1'b1;
      n = 0;
      i_read      <= ~w;
      i_write     <= w;
      i_address   <= a;
      i_writedata <= {24'h00_0000, d};
      while (wt !== 1'b0) begin
         @(negedge i_clk);
         wt = o_waitrequest;
         q = o_readdata[7:0];
         @(posedge i_clk);
         n++;
      end
      chk_int(int'(n >= 2), 1, "bus answer");
   endtask : bus

   task automatic rel();
      i_read  <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clk);
   endtask : rel

   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      rel();
   endtask : wr8

   task automatic rd8(input logic [3:0] a, input logic [7:0] exp, input string what);
      bus(1'b0, a, 8'h00);
      rel();
      chk8(q, exp, what);
   endtask : rd8

   task automatic wait_stat(input logic [7:0] exp);
      int n;
      n = 0;
      q = 8'hxx;
      while (q !== exp && n < 100) begin
         bus(1'b0, ADDR_SOURCE_STATUS, 8'h00);
         rel();
         n++;
      end
      chk8(q, exp, "status");
   endtask : wait_stat

   // measures the third full period, transitions skipped
   task automatic period_chk(input int exp);
      int   n, g, rises;
      logic p;
      n = 0;
      g = 0;
      rises = 0;
      p = o_sys_clk;
      while (rises < 4 && g < 8000) begin
         @(negedge i_clk);
         g++;
         n++;
         if (o_sys_clk === 1'b1 && p === 1'b0) begin
            rises++;
            if (rises == 4) chk_int(n, exp, "period");
            n = 0;
         end
         p = o_sys_clk;
      end
      chk_int(rises, 4, "clock edges");
      @(posedge i_clk);
   endtask : period_chk

   task automatic pre(input logic [7:0] a, input int gap, input logic [7:0] b);
      bus(1'b1, ADDR_PRESCALER, a);
      if (gap > 0) begin
         rel();
         repeat (gap) @(posedge i_clk);
      end
      bus(1'b1, ADDR_PRESCALER, b);
      rel();
   endtask : pre

   task automatic t_reset();
      rd8(ADDR_SELECT_CONTROL, 8'h48, "select");
      rd8(ADDR_SOURCE_CONFIG, 8'h20, "config");
      rd8(ADDR_PRESCALER, 8'h03, "divider");
      rd8(4'h2, 8'h00, "unmapped");
      wait_stat(8'h02);
      chk8(o_rc_startup_time, 8'h01, "rc start-up");
      chk8(o_rc_source_config, 8'h02, "rc config");
      period_chk(40);
      $display("test reset done");
   endtask : t_reset

   task automatic t_fields();
      wr8(ADDR_SELECT_CONTROL, 8'hea);
      rd8(ADDR_SELECT_CONTROL, 8'h68, "select fields");
      wr8(ADDR_SOURCE_CONFIG, 8'h22);
      rd8(ADDR_SOURCE_CONFIG, 8'h22, "config");
      chk8(o_ext_source_config, 8'h02, "ext config");
      wr8(ADDR_SOURCE_STATUS, 8'hff);
      wr8(4'h2, 8'hff);
      wait_stat(8'h02);
      $display("test fields done");
   endtask : t_fields

   // firmware order for source switches, rc to ext and back
   task automatic t_switch();
      wr8(ADDR_SELECT_CONTROL, 8'h6c);
      chk8(o_ext_osc_enable, 8'h01, "ext enable");
      chk8(o_ext_startup_time, 8'h02, "ext start-up");
      wait_stat(8'h03);
      wr8(ADDR_SELECT_CONTROL, 8'h6d);
      wr8(ADDR_SELECT_CONTROL, 8'h65);
      chk8(o_rc_osc_enable, 8'h00, "rc enable");
      wait_stat(8'h01);
      period_chk(64);
      wr8(ADDR_SELECT_CONTROL, 8'h6d);
      wait_stat(8'h03);
      wr8(ADDR_SELECT_CONTROL, 8'h6c);
      wr8(ADDR_SELECT_CONTROL, 8'h68);
      chk8(o_ext_osc_enable, 8'h00, "ext enable");
      wait_stat(8'h02);
      period_chk(40);
      $display("test switch done");
   endtask : t_switch

   task automatic t_codes();
      for (int c = 0; c <= 8; c++) begin
         pre(8'h80, 0, 8'(c));
         rd8(ADDR_PRESCALER, 8'(c), "divider code");
         period_chk(5 << c);
      end
      $display("test codes done");
   endtask : t_codes

   task automatic t_refuse();
      pre(8'h80, 0, 8'h01);
      wr8(ADDR_PRESCALER, 8'h02);
      pre(8'h80, 0, 8'h09);
      wr8(ADDR_PRESCALER, 8'h02);
      pre(8'h81, 0, 8'h02);
      pre(8'h80, 3, 8'h02);
      bus(1'b1, ADDR_PRESCALER, 8'h80);
      pre(8'h80, 1, 8'h02);
      rd8(ADDR_PRESCALER, 8'h01, "divider kept");
      period_chk(10);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_fuse_ext();
      int   n;
      logic p;
      n = 0;
      i_nrst <= 1'b0;
      i_source_config_fuses <= 4'he;
      i_startup_time_fuses <= 2'h2;
      i_divide_by_eight_fuse <= 1'b0;
      p = o_clock_output_pin;
      repeat (20) begin
         @(negedge i_clk);
         n += int'(o_clock_output_pin !== p);
         p = o_clock_output_pin;
      end
      chk_int(n > 3, 1, "pin in reset");
      @(posedge i_clk);
      i_nrst <= 1'b1;
      bus(1'b0, ADDR_SELECT_CONTROL, 8'h00);
      rel();
      chk8(q & 8'h31, 8'h21, "select after fuse");
      rd8(ADDR_SOURCE_CONFIG, 8'h2e, "config after fuse");
      rd8(ADDR_PRESCALER, 8'h00, "divider after fuse");
      $display("test fuse done");
   endtask : t_fuse_ext

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   initial begin
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      t_reset();
      t_fields();
      t_switch();
      t_codes();
      t_refuse();
      t_fuse_ext();
      complete_run();
   end

   initial begin
      repeat (80000) @(posedge i_clk);
      n_errors++;
      $display("ERROR %0t watchdog expired", $time);
      complete_run();
   end
endmodule : clock_switch_and_prescaler_tb_top
`default_nettype wire
